// file: core/spipc_pkg.sv
package spipc_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [31:0] SPIPC_OFS_CONTROL = 32'hE002_0000;
  localparam logic [31:0] SPIPC_OFS_STATUS = 32'hE002_0004;
  localparam logic [31:0] SPIPC_OFS_DATA = 32'hE002_0008;
  localparam logic [31:0] SPIPC_OFS_DIVIDER = 32'hE002_000C;
  localparam logic [31:0] SPIPC_OFS_INTFLAG = 32'hE002_001C;

  // ==========================================================
  // control field positions
  localparam int SPIPC_CTL_EXT = 2;
  localparam int SPIPC_CTL_PHASE = 3;
  localparam int SPIPC_CTL_POL = 4;
  localparam int SPIPC_CTL_MASTER_SELECT = 5;
  localparam int SPIPC_CTL_LSB_FIRST_ORDER = 6;
  localparam int SPIPC_CTL_IE = 7;
  localparam int SPIPC_CTL_LEN_LO = 8;
  localparam logic [15:0] SPIPC_CTL_USED_MASK = 16'h0FFC;

  // ==========================================================
  // status field positions
  localparam int SPIPC_STS_ABORT = 3;
  localparam int SPIPC_STS_MODE_FAULT = 4;
  localparam int SPIPC_STS_ROVR = 5;
  localparam int SPIPC_STS_WRITE_COLLISION = 6;
  localparam int SPIPC_STS_DONE = 7;
  localparam int SPIPC_INT_FLAG_BIT = 0;

  // ==========================================================
  // reset values and frame lengths
  localparam logic [15:0] SPIPC_CTL_RST = 16'h0000;
  localparam logic [15:0] SPIPC_DATA_RST = 16'h0000;
  localparam logic [7:0] SPIPC_DIV_RST = 8'h00;
  localparam logic SPIPC_FLAG_RST = 1'b0;
  localparam logic [4:0] SPIPC_LEN_BYTE = 5'h08;
  localparam logic [4:0] SPIPC_LEN_MAX = 5'h10;
  // pin sync order {sclk, ssel_n, miso, mosi}; select idles high
  localparam logic [3:0] SPIPC_SYNC_RST = 4'h4;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic wr;
    logic rd;
  } spipc_bus_req_type;

  typedef struct packed {
    logic sclk;
    logic ssel_n;
    logic miso;
    logic mosi;
  } spipc_pins_in_type;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spipc_pins_out_type;

  typedef enum logic [1:0] {
    SPIPC_ST_IDLE,
    SPIPC_ST_BUSY,
    SPIPC_ST_HOLD
  } spipc_state_type;

endpackage : spipc_pkg

// file: core/spipc_clk_divider.sv
`timescale 1ns/1ns
`default_nettype none

module spipc_clk_divider (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic [7:0] divider,
  // half period pulse
  output logic tick
);

  // ==========================================================
  // half period counter
  logic [6:0] half;
  logic [6:0] cnt_r;
  logic tick_r;

  // odd or tiny settings still give a clock, just not a specified one
  assign half = (divider[7:1] == 7'h00) ? 7'h01 : divider[7:1];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 7'h00;
      tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 7'h00;
      tick_r <= 1'b0;
    end else if (cnt_r >= half - 7'h01) begin
      cnt_r <= 7'h00;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'h01;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;

endmodule : spipc_clk_divider

`default_nettype wire

// file: core/spipc_port_control.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Function
// - every writable register takes byte, halfword and word writes via byte enables
// - all used register bits reset to zero
// - control register sits at window base and steers the port
// - length extension clear gives eight bit frames
// - phase clear samples first edge; slave framed by select
// - phase set samples second edge; transfer from first to last sampling edge
// - polarity bit picks idle clock level, zero idles low
// - control bit 5 picks slave or master role
// - control bit 6 picks msb first or lsb first
// - interrupt enable gates interrupt on completion, write collision or mode fault
// - length field picks 8 to 15 bits, code zero gives 16
// - status register is read only, shows port condition
// - data write gives next transmit frame, read gives last received
// - divider register sets master serial clock rate
// - separate read write interrupt flag register
// - flag set on enabled event, cleared only by writing one
// - done flag at end of master frame or last slave sample
module spipc_port_control
  import spipc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire spipc_bus_req_type bus_req,
  output logic [31:0] bus_rdata,
  // serial pins
  input wire spipc_pins_in_type pins_in,
  output spipc_pins_out_type pins_out,
  // interrupt request
  output logic irq
);

  // ==========================================================
  // pin synchronisers
  logic [3:0] pin_raw;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;

  assign pin_raw = {pins_in.sclk, pins_in.ssel_n, pins_in.miso, pins_in.mosi};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_r[gi] <= SPIPC_SYNC_RST[gi];
          sync2_r[gi] <= SPIPC_SYNC_RST[gi];
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  logic s_sclk;
  logic s_ssel_n;
  logic s_miso;
  logic s_mosi;

  assign s_sclk = sync2_r[3];
  assign s_ssel_n = sync2_r[2];
  assign s_miso = sync2_r[1];
  assign s_mosi = sync2_r[0];

  // ==========================================================
  // registers
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] tx_r;
  logic [15:0] rx_buf_r;
  logic [7:0] div_r;
  logic transfer_complete_r;
  logic write_collision_r;
  logic rovr_r;
  logic abort_r;
  logic mode_fault_r;
  logic stat_seen_r;
  logic mode_fault_seen_r;
  logic int_r;
  logic [31:0] rdata_r;

  // ==========================================================
  // control fields
  logic ext;
  logic clock_phase;
  logic clock_polarity;
  logic master;
  logic lsb_first_order;
  logic ie;
  logic [3:0] len_code;
  logic [4:0] flen;

  assign ext = ctrl_r[SPIPC_CTL_EXT];
  assign clock_phase = ctrl_r[SPIPC_CTL_PHASE];
  assign clock_polarity = ctrl_r[SPIPC_CTL_POL];
  assign master = ctrl_r[SPIPC_CTL_MASTER_SELECT];
  assign lsb_first_order = ctrl_r[SPIPC_CTL_LSB_FIRST_ORDER];
  assign ie = ctrl_r[SPIPC_CTL_IE];
  assign len_code = ctrl_r[SPIPC_CTL_LEN_LO +: 4];

  // codes 1 to 7 are undefined, treated as a byte
  assign flen = !ext ? SPIPC_LEN_BYTE :
                (len_code == 4'h0) ? SPIPC_LEN_MAX :
                len_code[3] ? {1'b0, len_code} : SPIPC_LEN_BYTE;

  // bit index on the wire for the idx-th bit of the frame
  function automatic logic [3:0] bit_pos(input logic [4:0] idx, input logic [4:0] len, input logic lsb);
    logic [4:0] t;
    t = len - idx - 5'h01;
    return lsb ? idx[3:0] : t[3:0];
  endfunction : bit_pos

  // ==========================================================
  // register decode
  logic hit_ctl;
  logic hit_sts;
  logic hit_data;
  logic hit_div;
  logic hit_int;
  logic wr_ctl;
  logic wr_data;
  logic wr_div;
  logic wr_int;
  logic rd_sts;
  logic rd_data;
  logic [15:0] wmask;

  assign hit_ctl = bus_req.addr == SPIPC_OFS_CONTROL;
  assign hit_sts = bus_req.addr == SPIPC_OFS_STATUS;
  assign hit_data = bus_req.addr == SPIPC_OFS_DATA;
  assign hit_div = bus_req.addr == SPIPC_OFS_DIVIDER;
  assign hit_int = bus_req.addr == SPIPC_OFS_INTFLAG;
  assign wr_ctl = bus_req.wr && hit_ctl;
  assign wr_data = bus_req.wr && hit_data;
  assign wr_div = bus_req.wr && hit_div;
  assign wr_int = bus_req.wr && hit_int;
  assign rd_sts = bus_req.rd && hit_sts;
  assign rd_data = bus_req.rd && hit_data;
  // lanes 2 and 3 hold no bits, so only lanes 0 and 1 merge
  assign wmask = {{8{bus_req.be[1]}}, {8{bus_req.be[0]}}};

  // ==========================================================
  // transfer engine signals
  spipc_state_type state_r;
  spipc_state_type state_nxt;
  logic [4:0] out_idx_r;
  logic [4:0] rx_cnt_r;
  logic [5:0] edge_cnt_r;
  logic first_r;
  logic sclk_lvl_r;
  logic sclk_prev_r;
  logic [15:0] rx_sh_r;
  logic [15:0] rx_sh_nxt;
  logic tick;

  logic busy;
  logic selected;
  logic sclk_chg;
  logic m_edge;
  logic m_lead;
  logic s_lead;
  logic s_trail;
  logic lead_ev;
  logic trail_ev;
  logic sample_ev;
  logic shift_ev;
  logic in_bit;
  logic done_ev;
  logic s_abort;
  logic mode_fault_ev;
  logic active;
  logic blocked;
  logic wr_data_ok;
  logic start;
  logic clr_data;
  logic write_collision_set;
  logic rovr_set;
  logic int_set;
  logic int_clr;

  assign busy = state_r == SPIPC_ST_BUSY;
  assign selected = !s_ssel_n;
  assign sclk_chg = sclk_prev_r != s_sclk;

  // master edges come from the divider, slave edges from the pin
  assign m_edge = master && busy && tick;
  assign m_lead = m_edge && (sclk_lvl_r == clock_polarity);
  assign s_lead = !master && busy && selected && sclk_chg && (s_sclk != clock_polarity);
  assign s_trail = !master && busy && selected && sclk_chg && (s_sclk == clock_polarity);
  assign lead_ev = m_lead || s_lead;
  assign trail_ev = (m_edge && !m_lead) || s_trail;
  assign sample_ev = clock_phase ? trail_ev : lead_ev;
  // phase set: first bit is already out, later bits move on lead edges
  assign shift_ev = clock_phase ? (lead_ev && !first_r) : trail_ev;
  assign in_bit = master ? s_miso : s_mosi;

  assign done_ev = master ? (m_edge && (edge_cnt_r == {flen, 1'b0} - 6'h01)) :
                   (sample_ev && (rx_cnt_r == flen - 5'h01));
  // phase set: a frame only counts once its first clock edge came
  assign s_abort = !master && busy && !selected && (!clock_phase || !first_r);
  assign mode_fault_ev = master && selected;

  assign active = busy && (master || !clock_phase || !first_r);
  assign blocked = active || (transfer_complete_r && !stat_seen_r);
  assign wr_data_ok = wr_data && !blocked;
  assign start = (state_r == SPIPC_ST_IDLE) &&
                 ((master && wr_data_ok && !selected) || (!master && selected));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SPIPC_ST_IDLE: begin
        if (start) begin
          state_nxt = SPIPC_ST_BUSY;
        end
      end
      SPIPC_ST_BUSY: begin
        if (mode_fault_ev || s_abort) begin
          state_nxt = SPIPC_ST_IDLE;
        end else if (done_ev) begin
          state_nxt = (!master && !clock_phase) ? SPIPC_ST_HOLD : SPIPC_ST_IDLE;
        end else if (!master && !selected) begin
          // phase set: select gone before any edge, no frame to abort
          state_nxt = SPIPC_ST_IDLE;
        end
      end
      SPIPC_ST_HOLD: begin
        if (!selected || master) begin
          state_nxt = SPIPC_ST_IDLE;
        end
      end
      default: begin
        state_nxt = SPIPC_ST_IDLE;
      end
    endcase
  end

  always_comb begin
    rx_sh_nxt = rx_sh_r;
    if (sample_ev) begin
      rx_sh_nxt[bit_pos(rx_cnt_r, flen, lsb_first_order)] = in_bit;
    end
  end

  spipc_clk_divider u_div (
    .clk(clk),
    .reset_n(reset_n),
    .run(master && busy),
    .divider(div_r),
    .tick(tick)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SPIPC_ST_IDLE;
      out_idx_r <= 5'h00;
      rx_cnt_r <= 5'h00;
      edge_cnt_r <= 6'h00;
      first_r <= 1'b0;
      sclk_lvl_r <= 1'b0;
      sclk_prev_r <= 1'b0;
      rx_sh_r <= SPIPC_DATA_RST;
    end else begin
      state_r <= state_nxt;
      sclk_prev_r <= s_sclk;
      if (start) begin
        out_idx_r <= 5'h00;
        rx_cnt_r <= 5'h00;
        edge_cnt_r <= 6'h00;
        first_r <= 1'b1;
        rx_sh_r <= SPIPC_DATA_RST;
      end else begin
        out_idx_r <= shift_ev ? out_idx_r + 5'h01 : out_idx_r;
        rx_cnt_r <= sample_ev ? rx_cnt_r + 5'h01 : rx_cnt_r;
        edge_cnt_r <= m_edge ? edge_cnt_r + 6'h01 : edge_cnt_r;
        first_r <= lead_ev ? 1'b0 : first_r;
        rx_sh_r <= rx_sh_nxt;
      end
      // 2*len toggles bring the clock back to idle by itself
      sclk_lvl_r <= busy ? (sclk_lvl_r ^ m_edge) : clock_polarity;
    end
  end

  // ==========================================================
  // status and flag updates, a set always beats a clear
  assign clr_data = (rd_data || wr_data) && stat_seen_r;
  assign write_collision_set = wr_data && blocked;
  assign rovr_set = done_ev && transfer_complete_r && !clr_data;
  assign int_set = ie && (done_ev || write_collision_set || (mode_fault_ev && !mode_fault_r));
  assign int_clr = wr_int && bus_req.be[0] && bus_req.wdata[SPIPC_INT_FLAG_BIT];

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctl) begin
      // reserved bits are dropped and read back zero
      ctrl_nxt = ((bus_req.wdata[15:0] & wmask) | (ctrl_r & ~wmask)) & SPIPC_CTL_USED_MASK;
    end
    if (mode_fault_ev) begin
      ctrl_nxt[SPIPC_CTL_MASTER_SELECT] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= SPIPC_CTL_RST;
      tx_r <= SPIPC_DATA_RST;
      rx_buf_r <= SPIPC_DATA_RST;
      div_r <= SPIPC_DIV_RST;
      transfer_complete_r <= SPIPC_FLAG_RST;
      write_collision_r <= SPIPC_FLAG_RST;
      rovr_r <= SPIPC_FLAG_RST;
      abort_r <= SPIPC_FLAG_RST;
      mode_fault_r <= SPIPC_FLAG_RST;
      stat_seen_r <= SPIPC_FLAG_RST;
      mode_fault_seen_r <= SPIPC_FLAG_RST;
      int_r <= SPIPC_FLAG_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_data_ok) begin
        tx_r <= (bus_req.wdata[15:0] & wmask) | (tx_r & ~wmask);
      end
      // the buffer refills only once software drained the previous frame
      if (done_ev && (!transfer_complete_r || clr_data)) begin
        rx_buf_r <= rx_sh_nxt;
      end
      if (wr_div) begin
        div_r <= bus_req.be[0] ? bus_req.wdata[7:0] : div_r;
      end
      transfer_complete_r <= done_ev || (transfer_complete_r && !clr_data);
      write_collision_r <= write_collision_set || (write_collision_r && !clr_data);
      rovr_r <= rovr_set || (rovr_r && !rd_sts);
      abort_r <= s_abort || (abort_r && !rd_sts);
      mode_fault_r <= mode_fault_ev || (mode_fault_r && !(wr_ctl && mode_fault_seen_r));
      stat_seen_r <= rd_sts || (stat_seen_r && !(rd_data || wr_data));
      mode_fault_seen_r <= rd_sts ? mode_fault_r : (mode_fault_seen_r && !wr_ctl);
      int_r <= int_set || (int_r && !int_clr);
    end
  end

  // ==========================================================
  // read data, valid only in the cycle after the strobe
  logic [7:0] sts_val;
  logic [31:0] rd_val;

  assign sts_val = {transfer_complete_r, write_collision_r, rovr_r, mode_fault_r, abort_r, 3'h0};
  assign rd_val = hit_ctl ? {16'h0000, ctrl_r} :
                  hit_sts ? {24'h000000, sts_val} :
                  hit_data ? {16'h0000, rx_buf_r} :
                  hit_div ? {24'h000000, div_r} :
                  hit_int ? {31'h00000000, int_r} : 32'h00000000;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= bus_req.rd ? rd_val : 32'h00000000;
    end
  end

  // ==========================================================
  // pin drivers
  spipc_pins_out_type pins_r;
  spipc_pins_out_type pins_nxt;
  logic out_bit;

  assign out_bit = tx_r[bit_pos(out_idx_r, flen, lsb_first_order)];

  // a mode fault clears the master bit, so the registered drivers drop two clocks after the fault
  always_comb begin
    pins_nxt.sclk_o = sclk_lvl_r;
    pins_nxt.sclk_oe = master;
    pins_nxt.mosi_o = out_bit;
    pins_nxt.mosi_oe = master;
    pins_nxt.miso_o = out_bit;
    pins_nxt.miso_oe = !master && selected;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pins_r <= '0;
    end else begin
      pins_r <= pins_nxt;
    end
  end

  assign pins_out = pins_r;
  assign bus_rdata = rdata_r;
  assign irq = int_r;

endmodule : spipc_port_control

`default_nettype wire

// file: verif/spipc_port_control_checker.sv
`timescale 1ns/1ns
`default_nettype none

module spipc_port_control_checker
  import spipc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched ports
  input wire spipc_bus_req_type bus_req,
  input wire logic [31:0] bus_rdata,
  input wire spipc_pins_in_type pins_in,
  input wire spipc_pins_out_type pins_out,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // decode
  wire logic rd_ctl = bus_req.rd && bus_req.addr == SPIPC_OFS_CONTROL;
  wire logic rd_sts = bus_req.rd && bus_req.addr == SPIPC_OFS_STATUS;
  wire logic rd_dat = bus_req.rd && bus_req.addr == SPIPC_OFS_DATA;
  wire logic mapped = bus_req.addr inside {SPIPC_OFS_CONTROL, SPIPC_OFS_STATUS, SPIPC_OFS_DATA,
    SPIPC_OFS_DIVIDER, SPIPC_OFS_INTFLAG};
  wire logic clr_flag = bus_req.wr && bus_req.addr == SPIPC_OFS_INTFLAG && bus_req.be[0] && bus_req.wdata[0];

  // ==========================================================
  // properties
  rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (bus_req.rd && !mapped |=> bus_rdata == 32'h0)
    else $error("unmapped read not zero");
  status_fields_a: assert property (rd_sts |=> bus_rdata[31:8] == 24'h0 && bus_rdata[2:0] == 3'h0)
    else $error("status read shows unused bits");
  ctl_reserved_a: assert property (rd_ctl |=> bus_rdata[1:0] == 2'h0 && bus_rdata[31:12] == 20'h0)
    else $error("control reserved bits not zero");
  data_upper_a: assert property (rd_dat |=> bus_rdata[31:16] == 16'h0)
    else $error("data read upper half not zero");
  flag_hold_a: assert property (irq && !clr_flag |=> irq)
    else $error("interrupt flag dropped without a clear");
  drive_pair_a: assert property (pins_out.mosi_oe == pins_out.sclk_oe)
    else $error("master drivers disagree");
  slave_quiet_a: assert property (pins_in.ssel_n [*4] |=> !pins_out.miso_oe)
    else $error("slave drives while not selected");
  fault_release_a: assert property (!pins_in.ssel_n [*6] |=> !pins_out.sclk_oe)
    else $error("master kept driving while selected");
  half_period_a: assert property (pins_out.sclk_oe && $changed(pins_out.sclk_o)
    |=> $stable(pins_out.sclk_o) [*3])
    else $error("serial clock half period too short");
endmodule : spipc_port_control_checker

bind spipc_port_control spipc_port_control_checker chk_i (.clk(clk), .reset_n(reset_n),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .pins_in(pins_in), .pins_out(pins_out), .irq(irq));

`default_nettype wire

// file: verif/spipc_remote_slave.sv
`timescale 1ns/1ns
`default_nettype none

module spipc_remote_slave (
  // serial pins
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // frame setup
  input wire logic arm,
  input wire logic clock_polarity,
  input wire logic clock_phase,
  input wire logic lsb_first_order,
  input wire logic [4:0] len,
  input wire logic [15:0] tx,
  output logic [15:0] rx
);
  int di = 0;
  int si = 0;

  function automatic int pos(input int k);
    return lsb_first_order ? k : int'(len) - 1 - k;
  endfunction : pos

  initial miso = 1'b0;
  always @(posedge arm) begin
    di = 0;
    si = 0;
    rx = 16'h0000;
    miso = tx[pos(0)];
  end
  // released line flips so a stale bit never passes as valid
  always @(sclk) begin
    if ((sclk != clock_polarity) != clock_phase) begin
      if (si < len) rx[pos(si)] = mosi;
      si++;
      if (clock_phase && si >= len) miso = ~miso;
    end else if (clock_phase) begin
      miso = di < len ? tx[pos(di)] : ~miso;
      di++;
    end else begin
      di++;
      miso = di < len ? tx[pos(di)] : ~miso;
    end
  end
endmodule : spipc_remote_slave

`default_nettype wire

// file: verif/test_spi_port_control_registers.sv
`timescale 1ns/1ns
`default_nettype none

module test_spi_port_control_registers
  import spipc_pkg::*;
  ;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  spipc_bus_req_type req = '0;
  logic [31:0] bus_rdata;
  spipc_pins_in_type pin_i;
  spipc_pins_out_type pin_o;
  logic irq;
  logic ssel_n = 1'b1;
  logic arm = 1'b0;
  logic slv_miso;
  logic [15:0] slv_rx;
  logic [15:0] slv_tx = 16'h0000;
  logic [4:0] slv_len = 5'h08;
  logic [15:0] ctl_r = 16'h0000;
  logic m_sclk = 1'b0;
  logic m_mosi = 1'b1;
  int edges = 0;
  int err_total = 0;
  int compares = 0;

  always #5 clk = ~clk;
  always @(pin_i.sclk) edges++;

  // bench plays the remote master while the port is a slave; mosi idles high
  assign pin_i.sclk = pin_o.sclk_oe ? pin_o.sclk_o : m_sclk;
  assign pin_i.mosi = pin_o.mosi_oe ? pin_o.mosi_o : m_mosi;
  assign pin_i.miso = pin_o.miso_oe ? pin_o.miso_o : slv_miso;
  assign pin_i.ssel_n = ssel_n;

  spipc_port_control dut (.clk(clk), .reset_n(reset_n), .bus_req(req), .bus_rdata(bus_rdata),
    .pins_in(pin_i), .pins_out(pin_o), .irq(irq));
  spipc_remote_slave slv (.sclk(pin_i.sclk), .mosi(pin_i.mosi), .miso(slv_miso), .arm(arm),
    .clock_polarity(ctl_r[SPIPC_CTL_POL]), .clock_phase(ctl_r[SPIPC_CTL_PHASE]), .lsb_first_order(ctl_r[SPIPC_CTL_LSB_FIRST_ORDER]),
    .len(slv_len), .tx(slv_tx), .rx(slv_rx));

  // ==========================================================
  // bus and compare helpers
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, want, seen);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.be <= be;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask : rd

  task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask : rc

  // remote slave is armed only after the idle level settles
  task automatic xfer(input logic [15:0] ctl, input logic [4:0] len, input logic [15:0] rtx,
      input logic [15:0] tx);
    wr(SPIPC_OFS_CONTROL, {16'h0, ctl}, 4'h3);
    ctl_r = ctl;
    slv_len = len;
    slv_tx = rtx;
    repeat (3) @(posedge clk);
    arm = 1'b1;
    #1 arm = 1'b0;
    edges = 0;
    wr(SPIPC_OFS_DATA, {16'h0, tx}, 4'h3);
  endtask : xfer

  task automatic wait_done(output logic [31:0] v);
    v = '0;
    for (int i = 0; i < 200 && v[SPIPC_STS_DONE] !== 1'b1; i++) rd(SPIPC_OFS_STATUS, v);
  endtask : wait_done

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rc("control", SPIPC_OFS_CONTROL, 32'h0);
    rc("status", SPIPC_OFS_STATUS, 32'h0);
    rc("data", SPIPC_OFS_DATA, 32'h0);
    rc("divider", SPIPC_OFS_DIVIDER, 32'h0);
    rc("int flag", SPIPC_OFS_INTFLAG, 32'h0);
    rc("unmapped", 32'hE002_0010, 32'h0);
    wr(SPIPC_OFS_STATUS, 32'hFF, 4'hF);
    rc("status ro", SPIPC_OFS_STATUS, 32'h0);
  endtask : t_reset

  task automatic t_ctl;
    wr(SPIPC_OFS_CONTROL, 32'hFFFF, 4'h3);
    rc("ctl all", SPIPC_OFS_CONTROL, 32'h0FFC);
    wr(SPIPC_OFS_CONTROL, 32'h0, 4'h2);
    rc("ctl lane", SPIPC_OFS_CONTROL, 32'h00FC);
    wr(SPIPC_OFS_CONTROL, 32'h0, 4'hF);
    wr(SPIPC_OFS_DIVIDER, 32'h8, 4'h1);
    rc("divider", SPIPC_OFS_DIVIDER, 32'h8);
  endtask : t_ctl

  task automatic t_msb;
    logic [31:0] s;
    xfer(16'h00A0, 5'h08, 16'h003C, 16'h00A5);
    wr(SPIPC_OFS_DATA, 32'hFF, 4'h1);
    wait_done(s);
    chk("status", s, 32'hC0);
    chk("edges", edges, 16);
    chk("irq", irq, 1'b1);
    chk("sent", slv_rx, 32'h00A5);
    rc("flag", SPIPC_OFS_INTFLAG, 32'h1);
    rc("received", SPIPC_OFS_DATA, 32'h003C);
    rc("sts clear", SPIPC_OFS_STATUS, 32'h0);
    wr(SPIPC_OFS_INTFLAG, 32'h1, 4'h1);
    @(negedge clk);
    chk("irq clear", irq, 1'b0);
    chk("idle low", pin_o.sclk_o, 1'b0);
  endtask : t_msb

  task automatic t_lsb12;
    logic [31:0] s;
    xfer(16'h0C7C, 5'h0C, 16'h0F35, 16'h0ABC);
    wait_done(s);
    chk("status", s, 32'h80);
    chk("edges", edges, 24);
    chk("irq off", irq, 1'b0);
    chk("sent", slv_rx, 32'h0ABC);
    rc("received", SPIPC_OFS_DATA, 32'h0F35);
    chk("idle high", pin_o.sclk_o, 1'b1);
  endtask : t_lsb12

  task automatic t_16;
    logic [31:0] s;
    xfer(16'h0024, 5'h10, 16'h5AC3, 16'hC3A5);
    wait_done(s);
    chk("edges", edges, 32);
    chk("sent", slv_rx, 32'hC3A5);
    rc("received", SPIPC_OFS_DATA, 32'h5AC3);
  endtask : t_16

  // phase one keeps the dropped select from flagging a slave abort
  task automatic t_fault;
    wr(SPIPC_OFS_CONTROL, 32'h28, 4'h1);
    @(posedge clk) ssel_n <= 1'b0;
    repeat (8) @(posedge clk);
    ssel_n <= 1'b1;
    rc("fault", SPIPC_OFS_STATUS, 32'h10);
    rc("role", SPIPC_OFS_CONTROL, 32'h08);
    wr(SPIPC_OFS_CONTROL, 32'h0, 4'h1);
    rc("fault clear", SPIPC_OFS_STATUS, 32'h0);
  endtask : t_fault

  // slave frame, 24 clocks a bit so the pin sync keeps up
  task automatic t_slave;
    logic [7:0] mtx = 8'h4D;
    logic [7:0] got;
    logic [31:0] s;
    got = 8'h00;
    wr(SPIPC_OFS_DATA, 32'h96, 4'h1);
    @(posedge clk) ssel_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int k = 7; k >= 0; k--) begin
      m_mosi <= mtx[k];
      repeat (8) @(posedge clk);
      got[k] = pin_o.miso_o;
      m_sclk <= 1'b1;
      repeat (8) @(posedge clk);
      m_sclk <= 1'b0;
      repeat (8) @(posedge clk);
    end
    ssel_n <= 1'b1;
    wait_done(s);
    chk("slave status", s, 32'h80);
    chk("slave sent", {24'h0, got}, 32'h96);
    rc("slave received", SPIPC_OFS_DATA, 32'h004D);
  endtask : t_slave

  task automatic conclude;
    $display("mismatches %0d of %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_ctl();
    t_msb();
    t_lsb12();
    t_16();
    t_fault();
    t_slave();
    conclude();
  end

  initial begin
    #200000;
    err_total++;
    conclude();
  end
endmodule : test_spi_port_control_registers

`default_nettype wire
